// ### inc/timer_pkg.sv
// Constants for the dual timer/counter with clock-out.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package timer_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL = 8'h88; // Run bits and flags
   localparam logic [7:0] IDX_MODE = 8'h89; // Gate, select, mode
   localparam logic [7:0] IDX_TL0  = 8'h8A; // Unit 0 low byte
   localparam logic [7:0] IDX_TL1  = 8'h8B; // Unit 1 low byte
   localparam logic [7:0] IDX_TH0  = 8'h8C; // Unit 0 high byte
   localparam logic [7:0] IDX_TH1  = 8'h8D; // Unit 1 high byte
   localparam logic [7:0] IDX_AUX  = 8'hA3; // Fast select, clock-out
   localparam logic [7:0] IDX_AUX3 = 8'hA4; // Unit 0 slow prescale

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_OVF1 = 7;
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_OVF0 = 5;
   localparam int CTRL_RUN0 = 4;
   localparam int M_GATE1   = 7;
   localparam int M_CT1     = 6;
   localparam int M_MODE1   = 4;
   localparam int M_GATE0   = 3;
   localparam int M_CT0     = 2;
   localparam int M_MODE0   = 0;
   localparam int AUX_FAST1 = 3;
   localparam int AUX_FAST0 = 2;
   localparam int AUX_CKOE1 = 1;
   localparam int AUX_CKOE0 = 0;
   localparam int AUX3_SLOW = 0;

   // ------------------------------------------------------------
   // Modes and prescaler
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_PWM    = 2'h0;
   localparam logic [1:0] MODE_WIDE   = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT  = 2'h3;
   localparam logic [3:0] DIV12_LAST  = 4'hB; // Divide by 12
   localparam logic [1:0] DIV48_LAST  = 2'h3; // Four /12 ticks
   localparam logic [3:0] DIV192_LAST = 4'hF; // Sixteen /12 ticks
   localparam logic [7:0] BYTE_MAX    = 8'hFF;
   localparam logic [15:0] WORD_MAX   = 16'hFFFF;

   // ------------------------------------------------------------
   // Bus
   // ------------------------------------------------------------
   localparam int ADDR_W     = 12;
   localparam int HTRANS_ACT = 1;  // Set for NONSEQ and SEQ
   localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### rtl/dual_timer_counter_clock_out.sv
// Two timer/counter units with clock-out, AHB-Lite registers.
// Assumes pins and ticks synchronous to i_clk.
// Function
// - Timer rate sysclk/12, fast select undivided
// - Unit 0 clock from three select bits
// - Count pin falling edges sampled each cycle
// - Increment visible cycle after detecting cycle
// - Count only when run and gate allow; split high byte needs unit 1 run only
// - Mode 0 rollover sets overflow flag
// - Mode 1 full 16-bit count
// - Mode 2 low byte reloads from high
// - Unit 1 mode 3 holds count
// - Unit 0 mode 3 low byte separate
// - Split high byte uses unit 1 run/flag
// - Clock-out: auto-reload, square wave pin
// - Clock-out overflow still sets flag
// - Unit 1 baud tick and clock-out together
// - Two-bit mode field decode
// - Unit 0 eight clock sources
// - Unit 1 four clock sources
// - Flag set by hw/sw, cleared on ack/sw
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module dual_timer_counter_clock_out
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // AHB-Lite slave
   input  wire logic              i_hsel,
   input  wire logic [ADDR_W-1:0] i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic                   o_hreadyout,
   output logic                   o_hresp,
   output logic [31:0]            o_hrdata,
   // Count, gate and tick inputs
   input  wire logic              i_unit0_count_pin,
   input  wire logic              i_unit1_count_pin,
   input  wire logic [1:0]        i_external_gate_input,
   input  wire logic              i_low_speed_rc_clock,
   input  wire logic              i_watchdog_prescaler_tick,
   input  wire logic              i_unit0_int_ack,
   input  wire logic              i_unit1_int_ack,
   // Timer outputs
   output logic                   o_unit0_clock_out_pin,
   output logic                   o_unit1_clock_out_pin,
   output logic                   o_unit0_overflow_flag,
   output logic                   o_unit1_overflow_flag,
   output logic                   o_unit1_overflow_tick
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic        run0;     // Unit 0 run control
      logic        run1;     // Unit 1 run control
      logic        ovf0;     // Unit 0 overflow flag
      logic        ovf1;     // Unit 1 overflow flag
      logic [7:0]  mode;     // Gate, select and mode fields
      logic [7:0]  tl0;      // Unit 0 low byte
      logic [7:0]  th0;      // Unit 0 high byte
      logic [7:0]  tl1;      // Unit 1 low byte
      logic [7:0]  th1;      // Unit 1 high byte
      logic [3:0]  aux;      // Fast selects, clock-out enables
      logic        slow;     // Unit 0 slow prescale
      logic [1:0]  samp;     // Last count pin samples
      logic [1:0]  fall;     // Falling edge seen last cycle
      logic [3:0]  p12;      // Divide-by-12 phase
      logic [1:0]  p48;      // Counts /12 ticks for /48
      logic [3:0]  p192;     // Counts /12 ticks for /192
      logic        ov1_tick; // Unit 1 overflow pulse
      logic        cko0;     // Unit 0 clock-out level
      logic        cko1;     // Unit 1 clock-out level
      logic        wpend;    // Write in data phase
      logic [7:0]  widx;     // Index of that write
      logic [31:0] rdata;    // Read data for the data phase
      logic        ready;    // Always-ready slave answer
   } state_t;

   state_t s;       // Registered state
   state_t next_s;  // Next state

   logic        t12;    // One /12 tick
   logic        t48;    // One /48 tick
   logic        t192;   // One /192 tick
   logic        en0;    // Unit 0 gate open
   logic        en1;    // Unit 1 gate open
   logic        src1;   // Unit 1 selected source tick
   logic        split;  // Unit 0 in split operation
   logic        hi_tk;  // Split high byte tick
   logic        hi_ov;  // Split high byte overflow
   logic [16:0] r0;     // Unit 0 step result
   logic [16:0] r1;     // Unit 1 step result
   logic        acc;    // Address phase accepted
   logic [7:0]  aidx;   // Address phase index

   // ------------------------------------------------------------
   // Unit 0 source select, indexed by slow, fast, counter bits
   // ------------------------------------------------------------
   function automatic logic sel0(input logic [2:0] k);
      logic r;
      r = 1'b0;
      case (k)
         3'h0:    r = t12;
         3'h1:    r = s.fall[0];
         3'h2:    r = 1'b1;
         3'h3:    r = i_low_speed_rc_clock;
         3'h4:    r = t48;
         3'h5:    r = i_watchdog_prescaler_tick;
         3'h6:    r = t192;
         3'h7:    r = s.ov1_tick;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // One count step of a unit; result is {overflow, th, tl}
   // ------------------------------------------------------------
   function automatic logic [16:0] step(
      input logic [1:0] md,
      input logic       tk,
      input logic       reload,
      input logic       lo_split,
      input logic [7:0] tl,
      input logic [7:0] th
   );
      logic [16:0] r;
      r = {1'b0, th, tl};
      if (tk && reload)
      begin
         // Clock-out forces auto-reload
         r = (tl == BYTE_MAX) ? {1'b1, th, th}
                              : {1'b0, th, tl + 8'h01};
      end
      else if (tk)
      begin
         case (md)
            MODE_PWM:
               r = {tl == BYTE_MAX, th, tl + 8'h01};
            MODE_WIDE:
               r = {{th, tl} == WORD_MAX,
                    {th, tl} + 16'h0001};
            MODE_RELOAD:
               r = (tl == BYTE_MAX) ? {1'b1, th, th}
                                    : {1'b0, th, tl + 8'h01};
            MODE_SPLIT:
               if (lo_split)
               begin
                  r = {tl == BYTE_MAX, th, tl + 8'h01};
               end
               else
               begin
                  r = {1'b0, th, tl};
               end
            default:
               r = {1'b0, th, tl};
         endcase
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;

      // Shared prescaler: /12, then /48 and /192 from it
      t12 = (s.p12 == DIV12_LAST);
      t48 = t12 && (s.p48 == DIV48_LAST);
      t192 = t12 && (s.p192 == DIV192_LAST);
      next_s.p12 = t12 ? 4'h0 : s.p12 + 4'h1;
      if (t12)
      begin
         next_s.p48 = s.p48 + 2'h1;
         next_s.p192 = s.p192 + 4'h1;
      end

      // Sample pins, flag high-then-low pairs
      next_s.samp = {i_unit1_count_pin, i_unit0_count_pin};
      next_s.fall = s.samp
         & ~{i_unit1_count_pin, i_unit0_count_pin};

      // Run and gate conditions
      en0 = s.run0 && (!s.mode[M_GATE0]
            || i_external_gate_input[0]);
      en1 = s.run1 && (!s.mode[M_GATE1]
            || i_external_gate_input[1]);

      // Unit 1 source, indexed by fast and counter bits
      case ({s.aux[AUX_FAST1], s.mode[M_CT1]})
         2'h0:    src1 = t12;
         2'h1:    src1 = s.fall[1];
         2'h2:    src1 = 1'b1;
         2'h3:    src1 = t48;
         default: src1 = 1'b0;
      endcase

      // Count both units
      split = (s.mode[M_MODE0 +: 2] == MODE_SPLIT)
              && !s.aux[AUX_CKOE0];
      r0 = step(s.mode[M_MODE0 +: 2],
                en0 && sel0({s.slow, s.aux[AUX_FAST0],
                             s.mode[M_CT0]}),
                s.aux[AUX_CKOE0], 1'b1, s.tl0, s.th0);
      r1 = step(s.mode[M_MODE1 +: 2], en1 && src1,
                s.aux[AUX_CKOE1], 1'b0, s.tl1, s.th1);
      next_s.tl0 = r0[7:0];
      next_s.th0 = r0[15:8];
      next_s.tl1 = r1[7:0];
      next_s.th1 = r1[15:8];

      // Split high byte: timer clock only, never the count pin, unit 1 run
      hi_tk = split && s.run1
              && sel0({s.slow, s.aux[AUX_FAST0], 1'b0});
      hi_ov = hi_tk && (s.th0 == BYTE_MAX);
      if (hi_tk)
      begin
         next_s.th0 = s.th0 + 8'h01;
      end

      // Baud-rate tick follows unit 1 overflow in any case
      next_s.ov1_tick = r1[16];

      // Clock-out pins toggle per overflow, low when off
      if (!s.aux[AUX_CKOE0])
      begin
         next_s.cko0 = 1'b0;
      end
      else if (r0[16])
      begin
         next_s.cko0 = !s.cko0;
      end
      if (!s.aux[AUX_CKOE1])
      begin
         next_s.cko1 = 1'b0;
      end
      else if (r1[16])
      begin
         next_s.cko1 = !s.cko1;
      end

      // Interrupt acknowledge clears flags
      if (i_unit0_int_ack)
      begin
         next_s.ovf0 = 1'b0;
      end
      if (i_unit1_int_ack)
      begin
         next_s.ovf1 = 1'b0;
      end

      // Data phase write; overrides the count update
      if (s.wpend)
      begin
         case (s.widx)
            IDX_CTRL:
            begin
               next_s.ovf1 = i_hwdata[CTRL_OVF1];
               next_s.run1 = i_hwdata[CTRL_RUN1];
               next_s.ovf0 = i_hwdata[CTRL_OVF0];
               next_s.run0 = i_hwdata[CTRL_RUN0];
            end
            IDX_MODE: next_s.mode = i_hwdata[7:0];
            IDX_TL0:  next_s.tl0 = i_hwdata[7:0];
            IDX_TH0:  next_s.th0 = i_hwdata[7:0];
            IDX_TL1:  next_s.tl1 = i_hwdata[7:0];
            IDX_TH1:  next_s.th1 = i_hwdata[7:0];
            IDX_AUX:  next_s.aux = i_hwdata[3:0];
            IDX_AUX3: next_s.slow = i_hwdata[AUX3_SLOW];
            default:  next_s.slow = s.slow;
         endcase
      end

      // Hardware set wins over any clear
      if (r0[16])
      begin
         next_s.ovf0 = 1'b1;
      end
      if (split ? hi_ov : r1[16])
      begin
         next_s.ovf1 = 1'b1;
      end

      // Address phase decode
      acc = i_hsel && i_htrans[HTRANS_ACT] && i_hready
            && (i_haddr[ADDR_W-1:10] == 2'h0)
            && (i_haddr[1:0] == 2'h0);
      aidx = i_haddr[9:2];
      next_s.wpend = acc && i_hwrite;
      next_s.widx = aidx;
      next_s.ready = 1'b1;

      // Read data from next state, so a write just done shows
      if (i_hsel && i_htrans[HTRANS_ACT] && i_hready
          && !i_hwrite)
      begin
         next_s.rdata = 32'h0000_0000;
         if (acc)
         begin
            case (aidx)
               IDX_CTRL:
                  next_s.rdata[7:4] = {next_s.ovf1, next_s.run1,
                                       next_s.ovf0, next_s.run0};
               IDX_MODE: next_s.rdata[7:0] = next_s.mode;
               IDX_TL0:  next_s.rdata[7:0] = next_s.tl0;
               IDX_TH0:  next_s.rdata[7:0] = next_s.th0;
               IDX_TL1:  next_s.rdata[7:0] = next_s.tl1;
               IDX_TH1:  next_s.rdata[7:0] = next_s.th1;
               IDX_AUX:  next_s.rdata[3:0] = next_s.aux;
               IDX_AUX3: next_s.rdata[AUX3_SLOW] = next_s.slow;
               default:  next_s.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s <= '0;
         s.ready <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs straight from state, o_hresp tied to OKAY
   // ------------------------------------------------------------
   assign o_hreadyout = s.ready;
   assign o_hresp = HRESP_OKAY;
   assign o_hrdata = s.rdata;
   assign o_unit0_clock_out_pin = s.cko0;
   assign o_unit1_clock_out_pin = s.cko1;
   assign o_unit0_overflow_flag = s.ovf0;
   assign o_unit1_overflow_flag = s.ovf1;
   assign o_unit1_overflow_tick = s.ov1_tick;

endmodule // dual_timer_counter_clock_out

// ### test/count_pin_model.sv
// Far-side model: count pins, gating inputs, tick sources.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ns
module count_pin_model
(
   // Clock
   input  wire logic i_clk,
   // Lines toward the block
   output logic       o_pin0,
   output logic       o_pin1,
   output logic [1:0] o_gate,
   output logic       o_rc,
   output logic       o_wdt
);
   // Pins idle high so only real falls count
   initial
   begin
      o_pin0 = 1'h1;
      o_pin1 = 1'h1;
      o_gate = 2'h0;
      o_rc   = 1'h0;
      o_wdt  = 1'h0;
   end
   // Opens or closes one unit's gating input
   task automatic gate(input int u, input logic v);
      @(posedge i_clk);
      o_gate[u] <= v;
   endtask
   // Sends n events: 0/1 pin falls, 2 slow RC tick, 3 watchdog tick
   task automatic burst(input int sel, input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         case (sel)
            0: o_pin0 <= 1'h0;
            1: o_pin1 <= 1'h0;
            2: o_rc <= 1'h1;
            default: o_wdt <= 1'h1;
         endcase
         @(posedge i_clk);
         o_rc <= 1'h0;
         o_wdt <= 1'h0;
         @(posedge i_clk);
         o_pin0 <= 1'h1;
         o_pin1 <= 1'h1;
         @(posedge i_clk);
      end
   endtask
endmodule // count_pin_model

// ### test/timer_checker_asserts.sv
// Port checks for the dual timer/counter block.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module timer_checker
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic              i_clk,
   input wire logic              i_rst,
   // Bus
   input wire logic              i_hsel,
   input wire logic [ADDR_W-1:0] i_haddr,
   input wire logic [1:0]        i_htrans,
   input wire logic              i_hwrite,
   input wire logic [31:0]       i_hwdata,
   input wire logic              i_hready,
   input wire logic              o_hreadyout,
   input wire logic              o_hresp,
   input wire logic [31:0]       o_hrdata,
   // Timer side
   input wire logic              i_unit0_int_ack,
   input wire logic              i_unit1_int_ack,
   input wire logic              o_unit0_clock_out_pin,
   input wire logic              o_unit1_overflow_flag,
   input wire logic              o_unit0_overflow_flag,
   input wire logic              o_unit1_overflow_tick
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic       wr_ctrl; // Control write in data phase
   logic       wr_mode; // Mode write in data phase
   logic       wr_aux;  // Aux write in data phase
   logic [1:0] mode0;   // Shadow of unit 0 mode
   logic       cko0;    // Shadow of unit 0 clock-out enable
   wire take = i_hsel && i_htrans[1] && i_hready;
   // Tracks writes so flag and pin changes have a known cause
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         {wr_ctrl, wr_mode, wr_aux, mode0, cko0} <= 6'h0;
      end
      else
      begin
         wr_ctrl <= take && i_hwrite && i_haddr[9:2] == IDX_CTRL;
         wr_mode <= take && i_hwrite && i_haddr[9:2] == IDX_MODE;
         wr_aux  <= take && i_hwrite && i_haddr[9:2] == IDX_AUX;
         mode0   <= wr_mode ? i_hwdata[1:0] : mode0;
         cko0    <= wr_aux ? i_hwdata[AUX_CKOE0] : cko0;
      end
   end
   sequence s_read;
      take && !i_hwrite;
   endsequence
   // Unit 1 overflow tick while unit 1 still owns its flag
   sequence s_tick;
      o_unit1_overflow_tick && $past(mode0) != MODE_SPLIT;
   endsequence
   a_ready_always: assert property (o_hreadyout && o_hresp == HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_rdata_upper: assert property (s_read |=> o_hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_rdata_hold: assert property (!(take && !i_hwrite) |=> $stable(o_hrdata))
      else $error("read data changed without a read");
   a_flag0_clear: assert property ($fell(o_unit0_overflow_flag) |->
      $past(i_unit0_int_ack) || $past(wr_ctrl))
      else $error("unit 0 flag cleared without cause");
   a_flag1_clear: assert property ($fell(o_unit1_overflow_flag) |->
      $past(i_unit1_int_ack) || $past(wr_ctrl))
      else $error("unit 1 flag cleared without cause");
   a_flag1_set: assert property ($rose(o_unit1_overflow_flag) |->
      o_unit1_overflow_tick || $past(wr_ctrl) || $past(mode0) == MODE_SPLIT)
      else $error("unit 1 flag set without cause");
   a_tick_flag: assert property (s_tick |-> o_unit1_overflow_flag)
      else $error("unit 1 overflow left flag clear");
   a_cko0_off: assert property (!cko0 && !$past(cko0)
      |-> !o_unit0_clock_out_pin)
      else $error("clock-out pin active while disabled");
endmodule // timer_checker
bind dual_timer_counter_clock_out timer_checker timer_checker_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
   .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_hrdata(o_hrdata), .i_unit0_int_ack(i_unit0_int_ack),
   .i_unit1_int_ack(i_unit1_int_ack),
   .o_unit0_clock_out_pin(o_unit0_clock_out_pin),
   .o_unit1_overflow_flag(o_unit1_overflow_flag),
   .o_unit0_overflow_flag(o_unit0_overflow_flag),
   .o_unit1_overflow_tick(o_unit1_overflow_tick));

// ### test/testbench.sv
// Self-checking bench for the dual timer/counter block.
// Assumes the pin model and the bound checker are compiled.
`timescale 1ns/1ns
module testbench;
   import timer_pkg::*;
   logic              i_clk = 1'h0, i_rst = 1'h1;
   logic              hsel = 1'h0, hwrite = 1'h0, rd_dp = 1'h0;
   logic              ack0 = 1'h0, ack1 = 1'h0, cko_q = 1'h0;
   logic [1:0]        htrans = 2'h0;
   logic [ADDR_W-1:0] haddr = '0;
   logic [31:0]       hwdata = 32'h0;
   logic [31:0]       exp_q[$];     // Expected read data
   logic [15:0]       seed = 16'hEF7A;
   wire               hready, pin0, pin1, rc, wdt, cko1, tick;
   wire  [1:0]        gate;
   wire  [31:0]       hrdata;
   int                n_fail = 0, n_checks = 0, n_tog = 0, n_tick = 0;
   int                tog, tk;
   localparam logic [7:0] REGS[8] = '{8'h88, 8'h89, 8'h8A, 8'h8B,
                                      8'h8C, 8'h8D, 8'hA3, 8'hA4};
   always #25 i_clk = ~i_clk;
   dual_timer_counter_clock_out dual_timer_counter_clock_out_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
      .o_hresp(), .o_hrdata(hrdata), .i_unit0_count_pin(pin0),
      .i_unit1_count_pin(pin1), .i_external_gate_input(gate),
      .i_low_speed_rc_clock(rc), .i_watchdog_prescaler_tick(wdt),
      .i_unit0_int_ack(ack0), .i_unit1_int_ack(ack1),
      .o_unit0_clock_out_pin(), .o_unit1_clock_out_pin(cko1),
      .o_unit0_overflow_flag(), .o_unit1_overflow_flag(),
      .o_unit1_overflow_tick(tick));
   count_pin_model m (.i_clk(i_clk), .o_pin0(pin0), .o_pin1(pin1),
      .o_gate(gate), .o_rc(rc), .o_wdt(wdt));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic cmp(input logic [31:0] e, input logic [31:0] a);
      n_checks++;
      if (a !== e)
      begin
         n_fail++;
         $display("Error at %0t: expected %h got %h", $time, e, a);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_rdy();
      @(posedge i_clk);
      while (hready !== 1'h1)
         @(posedge i_clk);
   endtask
   // Address phase held until ready, then data phase
   task automatic bus(input logic [7:0] idx, input logic w);
      @(posedge i_clk);
      {hsel, hwrite, htrans} <= {1'h1, w, 2'h2};
      haddr <= {2'h0, idx, 2'h0};
      wait_rdy();
      {hsel, htrans} <= 3'h0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(idx, 1'h1);
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(idx, 1'h0);
      exp_q.push_back({24'h0, e});
      rd_dp <= 1'h1;
      wait_rdy();
      rd_dp <= 1'h0;
   endtask
   // Counts one clock source for a gated window or an event burst
   task automatic src(input int u, input logic [2:0] s, input logic run,
                      input int win, input int n, input logic [7:0] e);
      wr(IDX_MODE, u ? {2'h2 | 2'(s[0]), 6'h10} : {5'h1, s[0], 2'h1});
      wr(IDX_AUX, u ? {4'h0, s[1], 3'h0} : {5'h0, s[1], 2'h0});
      wr(IDX_AUX3, {7'h0, s[2]});
      wr(IDX_TL0 + 8'(u), 8'h00);
      wr(IDX_CTRL, run ? (u ? 8'h40 : 8'h10) : 8'h00);
      m.gate(u, 1'h1);
      if (n == 0)
         repeat (win - 1) @(posedge i_clk);
      else
         m.burst(s == 3'h3 ? 2 : s == 3'h5 ? 3 : u, n);
      m.gate(u, 1'h0);
      rd(IDX_TL0 + 8'(u), e);
      rd(IDX_CTRL, run ? (u ? 8'h40 : 8'h10) : 8'h00);
   endtask
   // Fast count of one unit in a mode for a gated number of cycles
   task automatic step(input int u, input logic [1:0] md,
                       input logic [7:0] th, tl, input int cyc);
      wr(IDX_MODE, u ? {2'h2, md, 4'h0} : {4'h2, md});
      wr(IDX_AUX, 8'h0C);
      wr(IDX_TH0 + 8'(u), th);
      wr(IDX_TL0 + 8'(u), tl);
      wr(IDX_CTRL, u ? 8'h40 : 8'h10);
      m.gate(u, 1'h1);
      repeat (cyc - 1) @(posedge i_clk);
      m.gate(u, 1'h0);
   endtask
   // Watches reads, clock-out edges and overflow ticks
   always @(posedge i_clk)
   begin
      cko_q <= cko1;
      if (rd_dp)
         cmp(exp_q.pop_front(), hrdata);
      if (cko_q !== cko1)
         n_tog++;
      if (tick === 1'h1)
         n_tick++;
   end
   initial
   begin
      repeat (30000) @(posedge i_clk);
      n_fail++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'h0;
      foreach (REGS[i])
         rd(REGS[i], 8'h00);
      wr(8'h90, 8'h5A);
      rd(8'h90, 8'h00);
      wr(IDX_AUX, 8'hFF);
      rd(IDX_AUX, 8'h0F);
      wr(IDX_AUX3, 8'hFF);
      rd(IDX_AUX3, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         wr(IDX_TL0 + 8'(i), seed[7:0]);
         rd(IDX_TL0 + 8'(i), seed[7:0]);
      end
      $display("register test done");
      src(0, 3'h0, 1, 120, 0, 8'h0A);
      src(0, 3'h2, 1, 37, 0, 8'h25);
      src(0, 3'h1, 1, 0, 9, 8'h09);
      src(0, 3'h3, 1, 0, 6, 8'h06);
      src(0, 3'h4, 1, 480, 0, 8'h0A);
      src(0, 3'h5, 1, 0, 5, 8'h05);
      src(0, 3'h6, 1, 1920, 0, 8'h0A);
      src(1, 3'h0, 1, 120, 0, 8'h0A);
      src(1, 3'h1, 1, 0, 7, 8'h07);
      src(1, 3'h2, 1, 25, 0, 8'h19);
      src(1, 3'h3, 1, 480, 0, 8'h0A);
      src(0, 3'h2, 0, 20, 0, 8'h00);
      $display("clock source test done");
      step(1, MODE_RELOAD, 8'hF0, 8'hFE, 3);
      rd(IDX_TL1, 8'hF1);
      rd(IDX_TH1, 8'hF0);
      rd(IDX_CTRL, 8'hC0);
      step(0, MODE_WIDE, 8'hFF, 8'hFE, 3);
      rd(IDX_TL0, 8'h01);
      rd(IDX_TH0, 8'h00);
      step(0, MODE_PWM, 8'h33, 8'hFF, 2);
      rd(IDX_TL0, 8'h01);
      rd(IDX_TH0, 8'h33);
      rd(IDX_CTRL, 8'h30);
      ack0 <= 1'h1;
      @(posedge i_clk);
      ack0 <= 1'h0;
      rd(IDX_CTRL, 8'h10);
      step(1, MODE_SPLIT, 8'h00, 8'h55, 10);
      rd(IDX_TL1, 8'h55);
      // Stop unit 1 first, so the split high byte starts from FF
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE, 8'hBB);
      wr(IDX_TL0, 8'hFF);
      wr(IDX_TH0, 8'hFF);
      wr(IDX_CTRL, 8'h50);
      repeat (20) @(posedge i_clk);
      rd(IDX_TL0, 8'hFF);
      rd(IDX_CTRL, 8'hD0);
      m.gate(0, 1'h1);
      m.gate(0, 1'h0);
      rd(IDX_CTRL, 8'hF0);
      $display("mode test done");
      wr(IDX_CTRL, 8'h00);
      // Unit 0 counts unit 1 overflow ticks from its cleared low byte
      wr(IDX_MODE, 8'h84);
      wr(IDX_AUX, 8'h0C);
      wr(IDX_AUX3, 8'h01);
      wr(IDX_TH1, 8'hFE);
      wr(IDX_TL1, 8'hFE);
      wr(IDX_AUX, 8'h0E);
      wr(IDX_CTRL, 8'h50);
      tog = n_tog;
      tk = n_tick;
      m.gate(1, 1'h1);
      repeat (7) @(posedge i_clk);
      m.gate(1, 1'h0);
      repeat (4) @(posedge i_clk);
      cmp(32'(n_tog - tog), 32'h4);
      cmp(32'(n_tick - tk), 32'h4);
      rd(IDX_TL1, 8'hFE);
      rd(IDX_TL0, 8'h04);
      rd(IDX_CTRL, 8'hD0);
      ack1 <= 1'h1;
      @(posedge i_clk);
      ack1 <= 1'h0;
      rd(IDX_CTRL, 8'h50);
      wr(IDX_CTRL, 8'hC0);
      rd(IDX_CTRL, 8'hC0);
      $display("clock-out test done");
      conclude();
   end
endmodule // testbench
